// ### hdl/pwrseq_map.svh
// constants for the power sequencer: timing, limits, commands, fields
`ifndef PWRSEQ_MAP_SVH
`define PWRSEQ_MAP_SVH
// clock and time base
`define PS_CLK_NS 32'h0000_0004
`define PS_MS_NS 32'h000F_4240
`define PS_FSW_KHZ 32'h0000_023B
`define PS_INIT_PRECISE_MS 16'h0002
`define PS_INIT_NORMAL_MS 16'h0004
// voltage limits in mV
`define PS_VOUT_MIN_MV 16'h0258
`define PS_VOUT_MAX_MV 16'h0E10
`define PS_CEIL_NUM 16'h000B
`define PS_CEIL_DEN 16'h000A
`define PS_INPUT_LOW_LOCKOUT_MIN_MV 16'h0B22
`define PS_INPUT_LOW_LOCKOUT_MAX_MV 16'h3E80
`define PS_ADDR_BASE 7'h19
// command codes of the decoded serial-bus writes
`define PS_CMD_OPERATION 8'h01
`define PS_CMD_VOUT 8'h21
`define PS_CMD_INPUT_LOW_LOCKOUT 8'h35
`define PS_CMD_UV_RESP 8'h5A
`define PS_CMD_TON_DELAY 8'h60
`define PS_CMD_TON_RISE 8'h61
`define PS_CMD_PG_CFG 8'hD3
`define PS_CMD_PG_DELAY 8'hD4
`define PS_CMD_UV_DELAY 8'hD5
`define PS_CMD_MISC 8'hD6
// field positions
`define PS_OP_ON_BIT 7
`define PS_PG_POL_BIT 8
`define PS_MISC_DE_BIT 0
`define PS_MISC_COMP_BIT 1
`define PS_MISC_PRECISE_BIT 2
`define PS_MISC_SYNC_EXT_BIT 3
`define PS_MISC_SYNC_OUT_BIT 4
// reset values
`define PS_RST_PG_TOL 8'h0A
`define PS_RST_GAIN 8'h32
`define PS_RST_UV_RESP 2'h2
`define PS_RST_UV_RETRY 3'h7
`define PS_RST_INPUT_LOW_LOCKOUT_MV 14'h0B22
`define PS_RETRY_FOREVER 3'h7
`endif

// ### hdl/pwrseq_pkg.sv
// types shared by the power sequencer
`default_nettype none
package pwrseq_pkg;
  typedef enum logic [2:0] {
    S_OFF, S_DELAY, S_RAMP, S_COMP, S_RUN, S_UVWAIT, S_UVOFF, S_LATCH
  } seq_st_t;

  // one decoded write from the serial-bus target front end
  typedef struct packed {
    logic wr;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    seq_st_t st;
    logic [2:0] en_s, uv_s, tol_s, ll_s;
    logic en_f, uv_f, tol_f, ll_f;
    logic [2:0][9:0] sp;
    logic sp_ok;
    logic [11:0] strap_mv;
    logic [6:0] addr;
    logic [17:0] ms_pre;
    logic [15:0] ms_cnt, pg_cnt;
    logic pg_imm, pg, comp_start;
    logic [8:0] sw_cnt;
    logic [11:0] vout_cmd, tgt;
    logic [15:0] dly_ms, rise_ms, pgd_ms, uv_dly_ms;
    logic pgd_set, pg_pol, op_on, de_en, comp_en, precise;
    logic sync_ext, sync_out;
    logic [7:0] pg_tol, gain;
    logic [13:0] input_low_lockout_mv;
    logic [1:0] uv_resp;
    logic [2:0] uv_retry, retry_cnt;
  } seq_state_t;
endpackage
`default_nettype wire

// ### hdl/power_sequencer_supervisor.sv
// power sequencer and supervisor of a digital step-down module
// Function
// - settings arrive as decoded SMBus 2.0 target writes of PMBus commands.
// - only bus address and output ceiling come from straps; rest is writable.
// - ceiling is strap voltage plus 10%, at most 3.6V; programmed output is held at or below it.
// - output target programmable from 0.6V to 3.6V, within the ceiling.
// - voltage strap picks one table level, 0.60V lowest to 3.30V highest.
// - start delay runs from enable until the programmed time; ramp follows.
// - zero delay starts ramp after internal initialisation of 2ms precise, 4ms normal.
// - zero ramp time drives output to target at once.
// - good needs output in tolerance, no fault; limits, polarity settable.
// - power good waits a delay, default equal to ramp time, settable; none right after compensation.
// - sync pin is clock reference or, on internal oscillator, clock out.
// - fixed-frequency switching at nominal 571kHz from the system clock.
// - default auto-compensation once after ramp at 50% gain; then power good.
// - diode emulation cuts low-side drive at light load, single-phase only.
// - input lockout threshold 2.85V to 16V; no start while input low.
// - undervoltage response: run on, delayed latched stop, or retried stop.
// - default response shuts down at once and restarts once input recovers.
// - enable to ramp about 2ms in precise mode, up to 4ms normally.
`timescale 1ns/1ps
`default_nettype none
`include "pwrseq_map.svh"

module power_sequencer_supervisor #(
  parameter int CYC_PER_MS = `PS_MS_NS / `PS_CLK_NS
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic enable_pin_i,
  input wire logic [4:0] voltage_strap_pin_i,
  input wire logic [4:0] address_strap_pin_i,
  input wire pwrseq_pkg::cmd_t cmd_i,
  input wire logic vout_in_tol_i,
  input wire logic vin_low_i,
  input wire logic light_load_i,
  input wire logic fault_i,
  input wire logic comp_done_i,
  input wire logic single_phase_i,
  output logic [6:0] smbus_addr_o,
  output logic [11:0] vout_target_o,
  output logic [13:0] input_low_lockout_thresh_o,
  output logic [7:0] pg_tol_o,
  output logic [7:0] comp_gain_o,
  output logic regulate_o,
  output logic ramp_active_o,
  output logic comp_start_o,
  output logic low_side_off_o,
  output logic output_ok_flag_o,
  output logic pwm_tick_o,
  output logic pll_ext_o,
  output logic sync_o,
  output logic sync_oe_o
);
  localparam int SW_CYC = (`PS_MS_NS / `PS_CLK_NS) / `PS_FSW_KHZ;

  pwrseq_pkg::seq_state_t s, next_s;
  logic tick, en_req, active, cond;
  logic [15:0] vmax, ceil_mv, init_ms, wait_ms, pgd_ms;
  pwrseq_pkg::seq_st_t after_ramp;

  // strap code to output level in mV
  function automatic logic [11:0] volt_of(input logic [4:0] c);
    case (c)
      5'h00: volt_of = 12'h258;
      5'h01: volt_of = 12'h28A;
      5'h02: volt_of = 12'h2BC;
      5'h03: volt_of = 12'h2EE;
      5'h04: volt_of = 12'h320;
      5'h05: volt_of = 12'h352;
      5'h06: volt_of = 12'h384;
      5'h07: volt_of = 12'h3B6;
      5'h08: volt_of = 12'h3E8;
      5'h09: volt_of = 12'h41A;
      5'h0A: volt_of = 12'h44C;
      5'h0B: volt_of = 12'h47E;
      5'h0C: volt_of = 12'h4B0;
      5'h0D: volt_of = 12'h4E2;
      5'h0E: volt_of = 12'h514;
      5'h0F: volt_of = 12'h578;
      5'h10: volt_of = 12'h5DC;
      5'h11: volt_of = 12'h640;
      5'h12: volt_of = 12'h6A4;
      5'h13: volt_of = 12'h708;
      5'h14: volt_of = 12'h76C;
      5'h15: volt_of = 12'h7D0;
      5'h16: volt_of = 12'h834;
      5'h17: volt_of = 12'h898;
      5'h18: volt_of = 12'h8FC;
      5'h19: volt_of = 12'h9C4;
      5'h1A: volt_of = 12'hAF0;
      5'h1B: volt_of = 12'hBB8;
      default: volt_of = 12'hCE4; // codes above the table read as top
    endcase
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // a pin change counts once second and third stage agree
  function automatic logic filt(input logic [2:0] sh, input logic f);
    filt = (sh[1] == sh[2]) ? sh[2] : f;
  endfunction

  // shared timing and limit terms
  assign tick = s.ms_pre == 18'(CYC_PER_MS - 1);
  assign en_req = s.en_f | s.op_on;
  assign vmax = (16'(s.strap_mv) * `PS_CEIL_NUM) / `PS_CEIL_DEN;
  assign ceil_mv = (vmax < `PS_VOUT_MAX_MV) ? vmax : `PS_VOUT_MAX_MV;
  assign init_ms = s.precise ? `PS_INIT_PRECISE_MS : `PS_INIT_NORMAL_MS;
  // zero delay still waits for initialisation to finish
  assign wait_ms = (s.dly_ms > init_ms) ? s.dly_ms : init_ms;
  assign pgd_ms = s.pgd_set ? s.pgd_ms : s.rise_ms;
  assign after_ramp = s.comp_en ? pwrseq_pkg::S_COMP : pwrseq_pkg::S_RUN;
  assign active = (s.st == pwrseq_pkg::S_DELAY) ||
                  (s.st == pwrseq_pkg::S_RAMP) ||
                  (s.st == pwrseq_pkg::S_COMP) ||
                  (s.st == pwrseq_pkg::S_RUN);
  assign cond = s.tol_f & ~fault_i & ~s.uv_f;

  // next state of the whole block
  always_comb begin
    next_s = s;
    next_s.comp_start = 1'b0;
    // three-stage pin synchronisers
    next_s.en_s = {s.en_s[1:0], enable_pin_i};
    next_s.uv_s = {s.uv_s[1:0], vin_low_i};
    next_s.tol_s = {s.tol_s[1:0], vout_in_tol_i};
    next_s.ll_s = {s.ll_s[1:0], light_load_i};
    next_s.en_f = filt(s.en_s, s.en_f);
    next_s.uv_f = filt(s.uv_s, s.uv_f);
    next_s.tol_f = filt(s.tol_s, s.tol_f);
    next_s.ll_f = filt(s.ll_s, s.ll_f);
    next_s.sp = {s.sp[1:0], {address_strap_pin_i, voltage_strap_pin_i}};
    // straps caught once; reset zeros must leave all three stages first
    if (!s.sp_ok && (s.sp[1] == s.sp[2]) &&
        ((s.ms_pre >= 18'h0_0003) || (s.ms_cnt != 16'h0000))) begin
      next_s.sp_ok = 1'b1;
      next_s.strap_mv = volt_of(s.sp[2][4:0]);
      next_s.vout_cmd = volt_of(s.sp[2][4:0]);
      next_s.addr = `PS_ADDR_BASE + 7'(s.sp[2][9:5]);
    end
    // millisecond base and switching period
    next_s.ms_pre = tick ? 18'h0_0000 : s.ms_pre + 18'h0_0001;
    if (tick && (s.ms_cnt != 16'hFFFF)) begin
      next_s.ms_cnt = s.ms_cnt + 16'h0001;
    end
    next_s.sw_cnt = (s.sw_cnt == 9'(SW_CYC - 1)) ? 9'h000 :
                    s.sw_cnt + 9'h001;
    // decoded bus writes; every other setting lives here
    if (cmd_i.wr) begin
      case (cmd_i.code)
        `PS_CMD_OPERATION: next_s.op_on = cmd_i.data[`PS_OP_ON_BIT];
        `PS_CMD_VOUT: next_s.vout_cmd = 12'(clamp(cmd_i.data,
                        `PS_VOUT_MIN_MV, `PS_VOUT_MAX_MV));
        `PS_CMD_INPUT_LOW_LOCKOUT: next_s.input_low_lockout_mv = 14'(clamp(cmd_i.data,
                        `PS_INPUT_LOW_LOCKOUT_MIN_MV, `PS_INPUT_LOW_LOCKOUT_MAX_MV));
        `PS_CMD_UV_RESP: begin
          next_s.uv_resp = cmd_i.data[1:0];
          next_s.uv_retry = cmd_i.data[4:2];
        end
        `PS_CMD_TON_DELAY: next_s.dly_ms = cmd_i.data;
        `PS_CMD_TON_RISE: next_s.rise_ms = cmd_i.data;
        `PS_CMD_PG_CFG: begin
          next_s.pg_tol = cmd_i.data[7:0];
          next_s.pg_pol = cmd_i.data[`PS_PG_POL_BIT];
        end
        `PS_CMD_PG_DELAY: begin
          next_s.pgd_ms = cmd_i.data;
          next_s.pgd_set = 1'b1;
        end
        `PS_CMD_UV_DELAY: next_s.uv_dly_ms = cmd_i.data;
        `PS_CMD_MISC: begin
          next_s.de_en = cmd_i.data[`PS_MISC_DE_BIT];
          next_s.comp_en = cmd_i.data[`PS_MISC_COMP_BIT];
          next_s.precise = cmd_i.data[`PS_MISC_PRECISE_BIT];
          next_s.sync_ext = cmd_i.data[`PS_MISC_SYNC_EXT_BIT];
          next_s.sync_out = cmd_i.data[`PS_MISC_SYNC_OUT_BIT];
          next_s.gain = cmd_i.data[15:8];
        end
        default: ; // unknown codes are ignored
      endcase
    end
    // programmed target never passes the strap ceiling
    next_s.tgt = (16'(s.vout_cmd) > ceil_mv) ? 12'(ceil_mv) :
                 s.vout_cmd;
    // start-up sequence
    case (s.st)
      pwrseq_pkg::S_OFF: begin
        if (en_req && s.sp_ok && !s.uv_f) begin
          next_s.st = pwrseq_pkg::S_DELAY;
        end
      end
      pwrseq_pkg::S_DELAY: begin
        next_s.pg_imm = 1'b0;
        if (s.ms_cnt >= wait_ms) begin
          next_s.st = (s.rise_ms == 16'h0000) ? after_ramp :
                      pwrseq_pkg::S_RAMP;
        end
      end
      pwrseq_pkg::S_RAMP: begin
        if (s.ms_cnt >= s.rise_ms) begin
          next_s.st = after_ramp;
        end
      end
      pwrseq_pkg::S_COMP: begin
        if (comp_done_i) begin
          next_s.st = pwrseq_pkg::S_RUN;
          next_s.pg_imm = 1'b1;
        end
      end
      pwrseq_pkg::S_RUN: begin
        // good after the delay, or at once after the compensation pass
        if (cond) begin
          if (s.pg_imm || (s.pg_cnt >= pgd_ms)) begin
            next_s.pg = 1'b1;
          end else if (tick) begin
            next_s.pg_cnt = s.pg_cnt + 16'h0001;
          end
        end else begin
          next_s.pg = 1'b0;
          next_s.pg_cnt = 16'h0000;
          next_s.pg_imm = 1'b0;
        end
      end
      pwrseq_pkg::S_UVWAIT: begin
        if (!s.uv_f) begin
          next_s.st = pwrseq_pkg::S_RUN;
        end else if (s.ms_cnt >= s.uv_dly_ms) begin
          next_s.st = pwrseq_pkg::S_LATCH;
        end
      end
      pwrseq_pkg::S_UVOFF: begin
        // keep watching the input; restart while attempts remain
        if (!s.uv_f) begin
          if (s.uv_retry == `PS_RETRY_FOREVER) begin
            next_s.st = pwrseq_pkg::S_DELAY;
          end else if (s.retry_cnt < s.uv_retry) begin
            next_s.retry_cnt = s.retry_cnt + 3'h1;
            next_s.st = pwrseq_pkg::S_DELAY;
          end else begin
            next_s.st = pwrseq_pkg::S_LATCH;
          end
        end
      end
      pwrseq_pkg::S_LATCH: ; // left only by dropping enable
      default: next_s.st = pwrseq_pkg::S_OFF;
    endcase
    // undervoltage response while sequencing or running
    if (active && s.uv_f) begin
      case (s.uv_resp)
        2'h0: ; // ride through
        2'h1: next_s.st = pwrseq_pkg::S_UVWAIT;
        default: next_s.st = pwrseq_pkg::S_UVOFF;
      endcase
    end
    // losing enable always stops and rearms the retry budget
    if (!en_req) begin
      next_s.st = pwrseq_pkg::S_OFF;
      next_s.retry_cnt = 3'h0;
    end
    if (next_s.st != s.st) begin
      next_s.ms_cnt = 16'h0000;
      next_s.ms_pre = 18'h0_0000;
    end
    if (next_s.st != pwrseq_pkg::S_RUN) begin
      next_s.pg = 1'b0;
      next_s.pg_cnt = 16'h0000;
    end
    if ((next_s.st == pwrseq_pkg::S_COMP) &&
        (s.st != pwrseq_pkg::S_COMP)) begin
      next_s.comp_start = 1'b1;
    end
  end

  // single state register; clock enable low freezes everything
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.pg_tol <= `PS_RST_PG_TOL;
      s.gain <= `PS_RST_GAIN;
      s.comp_en <= 1'b1;
      s.uv_resp <= `PS_RST_UV_RESP;
      s.uv_retry <= `PS_RST_UV_RETRY;
      s.input_low_lockout_mv <= `PS_RST_INPUT_LOW_LOCKOUT_MV;
    end else if (clk_en_i) begin
      s <= next_s;
    end
  end

  // outputs
  assign smbus_addr_o = s.addr;
  assign vout_target_o = s.tgt;
  assign input_low_lockout_thresh_o = s.input_low_lockout_mv;
  assign pg_tol_o = s.pg_tol;
  assign comp_gain_o = s.gain;
  assign regulate_o = (s.st == pwrseq_pkg::S_RAMP) ||
                      (s.st == pwrseq_pkg::S_COMP) ||
                      (s.st == pwrseq_pkg::S_RUN) ||
                      (s.st == pwrseq_pkg::S_UVWAIT);
  assign ramp_active_o = s.st == pwrseq_pkg::S_RAMP;
  assign comp_start_o = s.comp_start;
  // multi-phase setups never emulate a diode
  assign low_side_off_o = s.de_en & single_phase_i & s.ll_f &
                          regulate_o;
  assign output_ok_flag_o = s.pg ^ s.pg_pol;
  assign pwm_tick_o = s.sw_cnt == 9'h000;
  assign pll_ext_o = s.sync_ext;
  assign sync_oe_o = s.sync_out & ~s.sync_ext;
  assign sync_o = sync_oe_o & (s.sw_cnt < 9'(SW_CYC / 2));
endmodule // power_sequencer_supervisor
`default_nettype wire

// ### testbench/pwrseq_chk.sv
// concurrent checks on the power sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "pwrseq_map.svh"
module pwrseq_chk (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [4:0] address_strap_pin_i,
  input wire pwrseq_pkg::cmd_t cmd_i,
  input wire logic fault_i,
  input wire logic single_phase_i,
  input wire logic [6:0] smbus_addr_o,
  input wire logic [11:0] vout_target_o,
  input wire logic [13:0] input_low_lockout_thresh_o,
  input wire logic regulate_o,
  input wire logic ramp_active_o,
  input wire logic comp_start_o,
  input wire logic low_side_off_o,
  input wire logic output_ok_flag_o,
  input wire logic pwm_tick_o,
  input wire logic pll_ext_o,
  input wire logic sync_oe_o
);
  logic pol;
  logic pg;
  logic [8:0] gap;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // own copy of the polarity bit so power good is judged unmasked
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i)
      pol <= 1'b0;
    else if (clk_en_i && cmd_i.wr && cmd_i.code == `PS_CMD_PG_CFG)
      pol <= cmd_i.data[`PS_PG_POL_BIT];
  end
  assign pg = output_ok_flag_o ^ pol;
  // cycles since last tick; 1FF means no tick seen yet
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i)
      gap <= 9'h1FF;
    else if (pwm_tick_o)
      gap <= 9'h000;
    else if (clk_en_i && gap != 9'h1FF)
      gap <= gap + 9'h001;
  end
  sequence s_one_cycle;
    comp_start_o ##1 !comp_start_o;
  endsequence
  a_ramp_powered: assert property (ramp_active_o |-> regulate_o)
    else $error("ramp without power stage");
  a_comp_single: assert property (comp_start_o |-> s_one_cycle)
    else $error("compensation start not a single pulse");
  a_comp_powered: assert property (comp_start_o |-> regulate_o)
    else $error("compensation started while off");
  a_pg_no_fault: assert property (pg && $past(rst_n_i) |->
    !$past(fault_i))
    else $error("power good held through a fault");
  a_de_single: assert property (low_side_off_o |-> single_phase_i)
    else $error("diode emulation in multi-phase");
  a_sync_dir: assert property (!(pll_ext_o && sync_oe_o))
    else $error("sync pin driven while used as reference");
  a_vout_cap: assert property (vout_target_o <= 12'hE10)
    else $error("output target above range");
  a_input_low_lockout_band: assert property (input_low_lockout_thresh_o >= 14'h0B22 &&
    input_low_lockout_thresh_o <= 14'h3E80)
    else $error("lockout threshold out of range");
  a_addr_strap: assert property (smbus_addr_o != 7'h00 |->
    smbus_addr_o == 7'h19 + {2'b00, address_strap_pin_i})
    else $error("bus address does not follow strap");
  a_tick_period: assert property (pwm_tick_o && gap != 9'h1FF |->
    gap == 9'h1B4)
    else $error("switching tick period wrong");
  a_tick_bound: assert property (gap != 9'h1FF |-> gap <= 9'h1B4)
    else $error("switching tick missing");
endmodule // pwrseq_chk
bind power_sequencer_supervisor pwrseq_chk chk (.sys_clk_i, .rst_n_i,
  .clk_en_i, .address_strap_pin_i, .cmd_i, .fault_i, .single_phase_i,
  .smbus_addr_o, .vout_target_o, .input_low_lockout_thresh_o, .regulate_o,
  .ramp_active_o, .comp_start_o, .low_side_off_o, .output_ok_flag_o,
  .pwm_tick_o, .pll_ext_o, .sync_oe_o);
`default_nettype wire

// ### testbench/host_model.sv
// serial-bus host model handing decoded command writes to the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk_i,
  output var pwrseq_pkg::cmd_t cmd_o
);
  initial cmd_o = '0;
  // one write; strobe stands for exactly one rising edge
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    @(negedge sys_clk_i);
    cmd_o = '{wr: 1'b1, code: code, data: data};
    @(negedge sys_clk_i);
    // released lines carry garbage, never the last word
    cmd_o = '{wr: 1'b0, code: ~code, data: ~data};
  endtask
endmodule // host_model
`default_nettype wire

// ### testbench/power_sequencer_supervisor_tb.sv
// self-checking bench for the power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pwrseq_map.svh"
module power_sequencer_supervisor_tb;
  localparam int MS = 20;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] voltage_strap_pin_i = 5'h08;
  logic vout_in_tol_i = 1'b0;
  logic vin_low_i = 1'b0;
  logic fault_i = 1'b0;
  logic comp_done_i = 1'b0;
  logic single_phase_i = 1'b1;
  pwrseq_pkg::cmd_t cmd_i;
  logic [6:0] smbus_addr_o;
  logic [11:0] vout_target_o;
  logic [13:0] input_low_lockout_thresh_o;
  logic [7:0] pg_tol_o, comp_gain_o;
  logic regulate_o, ramp_active_o, comp_start_o, low_side_off_o;
  logic output_ok_flag_o, pwm_tick_o, pll_ext_o, sync_o, sync_oe_o;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  // enable pin tied low: the bus alone turns the block on
  power_sequencer_supervisor #(.CYC_PER_MS(MS)) uut (
    .sys_clk_i, .rst_n_i, .clk_en_i(1'b1), .enable_pin_i(1'b0),
    .voltage_strap_pin_i, .address_strap_pin_i(5'h05), .cmd_i,
    .vout_in_tol_i, .vin_low_i, .light_load_i(1'b1), .fault_i,
    .comp_done_i, .single_phase_i, .smbus_addr_o, .vout_target_o,
    .input_low_lockout_thresh_o, .pg_tol_o, .comp_gain_o, .regulate_o, .ramp_active_o,
    .comp_start_o, .low_side_off_o, .output_ok_flag_o, .pwm_tick_o,
    .pll_ext_o, .sync_o, .sync_oe_o);
  host_model host (.sys_clk_i, .cmd_o(cmd_i));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  // hang guard, far above the few thousand cycles needed
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [4:0] code);
    rst_n_i = 1'b0;
    voltage_strap_pin_i = code;
    repeat (5) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
  endtask
  // write, then let field and clamped output settle
  task automatic sv(input logic [7:0] code, input logic [15:0] data);
    host.send(code, data);
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic wreg(input logic lvl, input int n);
    int k;
    k = 0;
    while (regulate_o !== lvl && k < n) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(16'(regulate_o), 16'(lvl));
  endtask
  task automatic t_ceiling();
    sv(`PS_CMD_VOUT, 16'h0E10);
    chk(16'(vout_target_o), 16'h044C);
    sv(`PS_CMD_VOUT, 16'h041A);
    chk(16'(vout_target_o), 16'h041A);
    sv(`PS_CMD_VOUT, 16'h0064);
    chk(16'(vout_target_o), 16'h0258);
    do_reset(5'h00);
    sv(`PS_CMD_VOUT, 16'h0E10);
    chk(16'(vout_target_o), 16'h0294);
    do_reset(5'h1B);
    sv(`PS_CMD_VOUT, 16'h0E10);
    chk(16'(vout_target_o), 16'h0CE4);
  endtask
  task automatic t_start();
    int k;
    sv(`PS_CMD_INPUT_LOW_LOCKOUT, 16'h03E8);
    chk(16'(input_low_lockout_thresh_o), 16'h0B22);
    sv(`PS_CMD_INPUT_LOW_LOCKOUT, 16'h4E20);
    chk(16'(input_low_lockout_thresh_o), 16'h3E80);
    sv(`PS_CMD_MISC, 16'h3203);
    sv(`PS_CMD_TON_DELAY, 16'h0000);
    sv(`PS_CMD_TON_RISE, 16'h0001);
    host.send(`PS_CMD_OPERATION, 16'h0080);
    repeat (3 * MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0000);
    wreg(1'b1, 2 * MS + 8);
    chk(16'(ramp_active_o), 16'h0001);
    k = 0;
    while (comp_start_o !== 1'b1 && k < 2 * MS) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(16'(comp_start_o), 16'h0001);
    vout_in_tol_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk(16'(output_ok_flag_o), 16'h0000);
    comp_done_i = 1'b1;
    @(negedge sys_clk_i);
    comp_done_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk(16'(output_ok_flag_o), 16'h0001);
    chk(16'(low_side_off_o), 16'h0001);
    single_phase_i = 1'b0;
    @(negedge sys_clk_i);
    chk(16'(low_side_off_o), 16'h0000);
    single_phase_i = 1'b1;
    fault_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(16'(output_ok_flag_o), 16'h0000);
    fault_i = 1'b0;
  endtask
  task automatic t_uv();
    vin_low_i = 1'b1;
    wreg(1'b0, 8);
    vin_low_i = 1'b0;
    wreg(1'b1, 6 * MS);
    sv(`PS_CMD_UV_RESP, 16'h0000);
    vin_low_i = 1'b1;
    repeat (MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0001);
    sv(`PS_CMD_UV_DELAY, 16'h0003);
    sv(`PS_CMD_UV_RESP, 16'h0001);
    repeat (MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0001);
    repeat (3 * MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0000);
    vin_low_i = 1'b0;
    repeat (6 * MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0000);
    sv(`PS_CMD_OPERATION, 16'h0000);
    sv(`PS_CMD_OPERATION, 16'h0080);
    wreg(1'b1, 6 * MS);
    sv(`PS_CMD_UV_RESP, 16'h0006);
    // one retry allowed: first recovery restarts, second stays latched
    for (int i = 0; i < 2; i++) begin
      vin_low_i = 1'b1;
      wreg(1'b0, 8);
      vin_low_i = 1'b0;
      repeat (8 * MS) @(negedge sys_clk_i);
      chk(16'(regulate_o), (i == 0) ? 16'h0001 : 16'h0000);
    end
  endtask
  task automatic t_cfg();
    int k;
    sv(`PS_CMD_PG_CFG, 16'h0105);
    chk(16'(pg_tol_o), 16'h0005);
    chk(16'(output_ok_flag_o), 16'h0001);
    sv(`PS_CMD_MISC, 16'h4013);
    chk(16'(comp_gain_o), 16'h0040);
    chk(16'({sync_oe_o, pll_ext_o}), 16'h0002);
    // clock out is high for the first half of each switching period
    k = 0;
    while (pwm_tick_o !== 1'b1 && k < 500) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(16'(sync_o), 16'h0001);
    repeat (220) @(negedge sys_clk_i);
    chk(16'(sync_o), 16'h0000);
    sv(`PS_CMD_MISC, 16'h4009);
    chk(16'({sync_oe_o, pll_ext_o}), 16'h0001);
    k = 0;
    while (pwm_tick_o !== 1'b1 && k < 500) begin
      @(negedge sys_clk_i);
      k++;
    end
    @(negedge sys_clk_i);
    k = 1;
    while (pwm_tick_o !== 1'b1 && k < 500) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk(16'(k), 16'h01B5);
  endtask
  // precise start, no ramp, no compensation, own power-good delay
  task automatic t_seq();
    sv(`PS_CMD_MISC, 16'h0004);
    sv(`PS_CMD_TON_RISE, 16'h0000);
    sv(`PS_CMD_PG_DELAY, 16'h0002);
    host.send(`PS_CMD_OPERATION, 16'h0080);
    repeat (MS) @(negedge sys_clk_i);
    chk(16'(regulate_o), 16'h0000);
    wreg(1'b1, MS + 8);
    chk(16'(ramp_active_o), 16'h0000);
    chk(16'(comp_start_o), 16'h0000);
    repeat (MS + 10) @(negedge sys_clk_i);
    chk(16'(output_ok_flag_o), 16'h0000);
    repeat (MS) @(negedge sys_clk_i);
    chk(16'(output_ok_flag_o), 16'h0001);
  endtask
  initial begin
    do_reset(5'h08);
    chk(16'(pg_tol_o), 16'h000A);
    chk(16'(comp_gain_o), 16'h0032);
    chk(16'(input_low_lockout_thresh_o), 16'h0B22);
    chk(16'(smbus_addr_o), 16'h001E);
    t_ceiling();
    do_reset(5'h08);
    t_start();
    t_uv();
    t_cfg();
    do_reset(5'h08);
    t_seq();
    tally_and_finish();
  end
endmodule // power_sequencer_supervisor_tb
`default_nettype wire
